// file: verilog/dcb_cv_bank.sv
// Configuration-variable bank top: direct settings, indexed window, drive and outputs
module dcb_cv_bank
  import dcb_pkg::*;
(
  // Clock and reset
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RST_N,
  // Variable access from the command decoder
  input  wire logic                   I_CV_WR,
  input  wire logic                   I_CV_RD,
  input  wire logic                   I_MAIN_LINE_PROGRAMMING,
  input  wire logic [8:0]             I_CV_NUM,
  input  wire logic [7:0]             I_CV_WDATA,
  output logic [7:0]                  O_CV_RDATA,
  output logic                        O_CV_ACK,
  output logic                        O_CV_ERR,
  // Locomotive state
  input  wire logic [7:0]             I_SPEED,
  input  wire logic [7:0]             I_CORRECTION,
  input  wire logic                   I_FORWARD,
  input  wire logic [NUM_KEYS-1:0]    I_KEYS,
  // Drive and outputs
  output logic                        O_MOTOR_PWM,
  output logic                        O_COMP_ACTIVE,
  output logic                        O_FAST_PWM,
  output logic                        O_SERIAL_FN_EN,
  output logic [NUM_OUTPUTS-1:0]      O_FUNC_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] start_voltage;
  logic [7:0] index_page_high;
  logic [7:0] index_page_low;
  logic [7:0] motor_config;
  logic [7:0] control_influence;
  logic [7:0] extended_config;
  logic [7:0] direct_mem [512];
  logic [7:0] window_mem [PAGE_COUNT*WINDOW_SIZE];

  // Mapping rows
  logic [7:0] row_key_mem [NUM_ROWS];
  logic [7:0] row_out_mem [NUM_ROWS];
  logic [NUM_ROWS*8-1:0] row_key_bus;
  logic [NUM_ROWS*8-1:0] row_out_bus;

  // Access capture and decode
  dcb_state_t state;
  logic [8:0]  acc_num;
  logic [7:0]  acc_data;
  logic        page_ok;
  logic        in_window;
  logic [10:0] win_addr;
  logic [3:0]  map_row;
  logic [3:0]  map_col;
  logic        map_write;
  logic        access_done;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic logic is_window(input logic [8:0] n);
    is_window = (n >= CV_WINDOW_FIRST) && (n <= CV_WINDOW_LAST);
  endfunction

  function automatic logic is_named(input logic [8:0] n);
    is_named = (n == CV_START_VOLTAGE) || (n == CV_INDEX_PAGE_HIGH) ||
               (n == CV_INDEX_PAGE_LOW) || (n == CV_MOTOR_CONFIG) ||
               (n == CV_CONTROL_INFLUENCE) || (n == CV_EXTENDED_CONFIG);
  endfunction

  always_comb begin
    in_window = is_window(acc_num);
    page_ok   = (index_page_high == INDEX_HIGH_VALID) && (index_page_low <= PAGE_LAST);
    win_addr  = 11'(index_page_low[2:0]) * 11'(WINDOW_SIZE) + 11'(acc_num[7:0]);
    map_row   = 4'((acc_num - CV_WINDOW_FIRST) >> 4);
    map_col   = 4'(acc_num - CV_WINDOW_FIRST);
    map_write = (state == ST_WRITE) && in_window && page_ok && (index_page_low == 8'h02);
    access_done = (state == ST_READ) || (state == ST_WRITE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing: capture, then read or write next cycle
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      acc_num  <= '0;
      acc_data <= '0;
    end else if (state == ST_IDLE) begin
      acc_num  <= I_CV_NUM;
      acc_data <= I_CV_WDATA;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (I_CV_WR) begin
            state <= ST_WRITE;
          end else if (I_CV_RD) begin
            state <= ST_READ;
          end
        end
        ST_READ: begin
          state <= ST_IDLE;
        end
        ST_WRITE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Named settings, one register each
  function automatic logic named_write(input dcb_state_t s, input logic [8:0] n,
                                       input logic [8:0] target);
    named_write = (s == ST_WRITE) && (n == target);
  endfunction

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      start_voltage <= RST_START_VOLTAGE;
    end else if (named_write(state, acc_num, CV_START_VOLTAGE)) begin
      start_voltage <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      index_page_high <= RST_INDEX_HIGH;
    end else if (named_write(state, acc_num, CV_INDEX_PAGE_HIGH)) begin
      index_page_high <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      index_page_low <= RST_INDEX_LOW;
    end else if (named_write(state, acc_num, CV_INDEX_PAGE_LOW)) begin
      index_page_low <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      motor_config <= RST_MOTOR_CONFIG;
    end else if (named_write(state, acc_num, CV_MOTOR_CONFIG)) begin
      motor_config <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      control_influence <= RST_CONTROL_INFL;
    end else if (named_write(state, acc_num, CV_CONTROL_INFLUENCE)) begin
      control_influence <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      extended_config <= RST_EXTENDED_CONFIG;
    end else if (named_write(state, acc_num, CV_EXTENDED_CONFIG)) begin
      extended_config <= acc_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Other directly numbered variables and the window store
  always_ff @(posedge I_MCLK) begin
    if (state == ST_WRITE && !in_window && !is_named(acc_num)) begin
      direct_mem[acc_num] <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (state == ST_WRITE && in_window && page_ok) begin
      window_mem[win_addr] <= acc_data;
    end
  end

  // Page 2 rows 1..16: column A is the key condition, column J the outputs
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      for (int r = 0; r < NUM_ROWS; r++) begin
        row_key_mem[r] <= '0;
      end
    end else if (map_write && map_col == 4'h0) begin
      row_key_mem[map_row] <= acc_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      for (int r = 0; r < NUM_ROWS; r++) begin
        row_out_mem[r] <= '0;
      end
    end else if (map_write && map_col == 4'h9) begin
      row_out_mem[map_row] <= acc_data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_ROWS; g++) begin : gen_rowbus
      assign row_key_bus[g*8 +: 8] = row_key_mem[g];
      assign row_out_bus[g*8 +: 8] = row_out_mem[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the command decoder
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_CV_ACK <= 1'b0;
      O_CV_ERR <= 1'b0;
    end else begin
      O_CV_ACK <= access_done;
      O_CV_ERR <= access_done && in_window && !page_ok;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_CV_RDATA <= '0;
    end else if (state == ST_READ) begin
      if (in_window) begin
        O_CV_RDATA <= page_ok ? window_mem[win_addr] : 8'h00;
      end else begin
        case (acc_num)
          CV_START_VOLTAGE:     O_CV_RDATA <= start_voltage;
          CV_INDEX_PAGE_HIGH:   O_CV_RDATA <= index_page_high;
          CV_INDEX_PAGE_LOW:    O_CV_RDATA <= index_page_low;
          CV_MOTOR_CONFIG:      O_CV_RDATA <= motor_config;
          CV_CONTROL_INFLUENCE: O_CV_RDATA <= control_influence;
          CV_EXTENDED_CONFIG:   O_CV_RDATA <= extended_config;
          default:              O_CV_RDATA <= direct_mem[acc_num];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings driving the block
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_FAST_PWM <= RST_MOTOR_CONFIG[MOTOR_CFG_FAST_PWM_BIT];
    end else begin
      O_FAST_PWM <= motor_config[MOTOR_CFG_FAST_PWM_BIT];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_SERIAL_FN_EN <= RST_EXTENDED_CONFIG[EXT_CFG_SERIAL_FN_BIT];
    end else begin
      O_SERIAL_FN_EN <= extended_config[EXT_CFG_SERIAL_FN_BIT];
    end
  end

  dcb_motor_pwm u_pwm (
    .i_clk           (I_MCLK),
    .i_rst_n         (I_RST_N),
    .i_fast_pwm      (motor_config[MOTOR_CFG_FAST_PWM_BIT]),
    .i_influence     (control_influence),
    .i_start_voltage (start_voltage),
    .i_speed         (I_SPEED),
    .i_correction    (I_CORRECTION),
    .o_pwm           (O_MOTOR_PWM),
    .o_comp_active   (O_COMP_ACTIVE)
  );

  dcb_func_map u_map (
    .i_clk     (I_MCLK),
    .i_rst_n   (I_RST_N),
    .i_keys    (I_KEYS),
    .i_forward (I_FORWARD),
    .i_moving  (I_SPEED != 8'h00),
    .i_row_key (row_key_bus),
    .i_row_out (row_out_bus),
    .o_outputs (O_FUNC_OUT)
  );
endmodule

// file: verilog/dcb_pkg.sv
// Constants for the decoder configuration-variable bank
package dcb_pkg;
  // Variable numbers of directly addressed settings
  localparam logic [8:0] CV_START_VOLTAGE    = 9'h002;
  localparam logic [8:0] CV_INDEX_PAGE_HIGH  = 9'h01f;
  localparam logic [8:0] CV_INDEX_PAGE_LOW   = 9'h020;
  localparam logic [8:0] CV_MOTOR_CONFIG     = 9'h031;
  localparam logic [8:0] CV_CONTROL_INFLUENCE = 9'h038;
  localparam logic [8:0] CV_EXTENDED_CONFIG  = 9'h07c;
  // Indexed window bounds
  localparam logic [8:0] CV_WINDOW_FIRST     = 9'h101;
  localparam logic [8:0] CV_WINDOW_LAST      = 9'h1ff;
  localparam logic [7:0] INDEX_HIGH_VALID    = 8'h10;
  localparam int         PAGE_COUNT          = 5;
  localparam logic [7:0] PAGE_LAST           = 8'h04;
  localparam int         WINDOW_SIZE         = 256;
  // Field positions
  localparam int         MOTOR_CFG_FAST_PWM_BIT = 1;
  localparam int         EXT_CFG_SERIAL_FN_BIT  = 3;
  // Values after reset (factory defaults)
  localparam logic [7:0] RST_START_VOLTAGE   = 8'h03;
  localparam logic [7:0] RST_INDEX_HIGH      = 8'h10;
  localparam logic [7:0] RST_INDEX_LOW       = 8'h00;
  localparam logic [7:0] RST_MOTOR_CONFIG    = 8'h02;
  localparam logic [7:0] RST_CONTROL_INFL    = 8'hff;
  localparam logic [7:0] RST_EXTENDED_CONFIG = 8'h14;
  // PWM timing at 25 MHz
  localparam int         CLK_HZ              = 25000000;
  localparam int         PWM_FAST_HZ         = 40000;
  localparam int         PWM_SLOW_HZ         = 20000;
  localparam int         PWM_FAST_CYCLES     = CLK_HZ / PWM_FAST_HZ;
  localparam int         PWM_SLOW_CYCLES     = CLK_HZ / PWM_SLOW_HZ;
  localparam int         PWM_CNT_W           = 11;
  // Function outputs
  localparam int         NUM_OUTPUTS         = 6;
  localparam int         NUM_KEYS            = 29;
  localparam int         NUM_ROWS            = 16;
  // Access state machine
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } dcb_state_t;
endpackage

// file: verilog/dcb_motor_pwm.sv
// Motor PWM generator with influence-scaled load compensation
module dcb_motor_pwm
  import dcb_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Settings
  input  wire logic       i_fast_pwm,
  input  wire logic [7:0] i_influence,
  input  wire logic [7:0] i_start_voltage,
  // Speed and regulation
  input  wire logic [7:0] i_speed,
  input  wire logic [7:0] i_correction,
  // Drive
  output logic            o_pwm,
  output logic            o_comp_active
);
  logic [PWM_CNT_W-1:0] cnt;
  logic [PWM_CNT_W-1:0] period;
  logic [15:0]          eff_infl;
  logic [15:0]          corr_scaled;
  logic [8:0]           duty;
  logic [9:0]           duty_sum;
  logic [PWM_CNT_W-1:0] thresh;
  logic [18:0]          thresh_wide;

  always_comb begin
    period = i_fast_pwm ? PWM_CNT_W'(PWM_FAST_CYCLES) : PWM_CNT_W'(PWM_SLOW_CYCLES);
    // Influence fades toward top speed unless full
    if (i_influence == 8'hff) begin
      eff_infl = {8'h00, i_influence};
    end else begin
      eff_infl = (16'(i_influence) * 16'(8'hff - i_speed)) >> 8;
    end
    corr_scaled = (16'(i_correction) * eff_infl) >> 8;
    if (i_speed == 8'h00) begin
      duty_sum = 10'h000;
    end else if (i_influence == 8'h00) begin
      duty_sum = 10'(i_start_voltage) + 10'(i_speed);
    end else begin
      duty_sum = 10'(i_start_voltage) + 10'(i_speed) + 10'(corr_scaled[7:0]);
    end
    duty = (duty_sum > 10'h0ff) ? 9'h0ff : duty_sum[8:0];
    thresh_wide = (19'(duty) * 19'(period)) >> 8;
    thresh = thresh_wide[PWM_CNT_W-1:0];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else if (cnt >= period - PWM_CNT_W'(1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + PWM_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pwm         <= 1'b0;
      o_comp_active <= 1'b0;
    end else begin
      o_pwm         <= cnt < thresh;
      o_comp_active <= i_influence != 8'h00;
    end
  end
endmodule

// file: verilog/dcb_func_map.sv
// Function key to output mapping from indexed mapping rows
module dcb_func_map
  import dcb_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Keys and travel state
  input  wire logic [NUM_KEYS-1:0]    i_keys,
  input  wire logic                   i_forward,
  input  wire logic                   i_moving,
  // Rows: condition key, direction mask, output mask
  input  wire logic [NUM_ROWS*8-1:0]  i_row_key,
  input  wire logic [NUM_ROWS*8-1:0]  i_row_out,
  // Outputs
  output logic [NUM_OUTPUTS-1:0]      o_outputs
);
  logic [NUM_OUTPUTS-1:0] row_hit [NUM_ROWS];
  logic [NUM_OUTPUTS-1:0] next_outputs;

  // Row key byte: [4:0] key number, [5] forward ok, [6] reverse ok, [7] stationary only
  function automatic logic row_match(input logic [7:0] k, input logic [NUM_KEYS-1:0] keys,
                                     input logic fwd, input logic mov);
    logic key_on;
    logic dir_ok;
    key_on = (k[4:0] < 5'(NUM_KEYS)) ? keys[k[4:0]] : 1'b0;
    dir_ok = fwd ? k[5] : k[6];
    row_match = key_on && dir_ok && !(k[7] && mov);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_ROWS; g++) begin : gen_rows
      assign row_hit[g] = row_match(i_row_key[g*8 +: 8], i_keys, i_forward, i_moving)
                          ? i_row_out[g*8 +: NUM_OUTPUTS] : '0;
    end
  endgenerate

  always_comb begin
    next_outputs = '0;
    for (int r = 0; r < NUM_ROWS; r++) begin
      next_outputs = next_outputs | row_hit[r];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_outputs <= '0;
    end else begin
      o_outputs <= next_outputs;
    end
  end
endmodule

// file: tb/dcb_chk.sv
// Port checker for the configuration-variable bank
module dcb_chk
  import dcb_pkg::*;
(
  // Clock and reset
  input wire logic       I_MCLK,
  input wire logic       I_RST_N,
  // Access
  input wire logic       I_CV_WR,
  input wire logic       I_CV_RD,
  input wire logic [8:0] I_CV_NUM,
  input wire logic [7:0] I_CV_WDATA,
  input wire logic       O_CV_ACK,
  input wire logic       O_CV_ERR,
  // Settings
  input wire logic       O_COMP_ACTIVE,
  input wire logic       O_FAST_PWM,
  input wire logic       O_SERIAL_FN_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken;
  logic taken_d;
  logic wtake;
  ////////////////////////////////////////////////////////////////////////////
  assign taken = (I_CV_WR | I_CV_RD) & ~taken_d;
  assign wtake = taken & I_CV_WR;
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      taken_d <= 1'b0;
    end else begin
      taken_d <= taken;
    end
  end
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_latency: assert property (taken |-> ##2 O_CV_ACK)
    else $error("access not answered two edges after request");
  a_ack_cause: assert property (O_CV_ACK |-> $past(taken, 2))
    else $error("answer without request");
  a_ack_pulse: assert property (O_CV_ACK |=> !O_CV_ACK)
    else $error("answer longer than one cycle");
  a_err_window: assert property (O_CV_ERR |-> O_CV_ACK && $past(I_CV_NUM, 2) >= CV_WINDOW_FIRST)
    else $error("error flag outside windowed answer");
  a_infl_off: assert property (wtake && I_CV_NUM == CV_CONTROL_INFLUENCE &&
    I_CV_WDATA == 8'h00 |-> ##[1:4] !O_COMP_ACTIVE)
    else $error("compensation kept with zero influence");
  a_infl_on: assert property (wtake && I_CV_NUM == CV_CONTROL_INFLUENCE &&
    I_CV_WDATA != 8'h00 |-> ##[1:4] O_COMP_ACTIVE)
    else $error("compensation off with nonzero influence");
  a_slow_pwm: assert property (wtake && I_CV_NUM == CV_MOTOR_CONFIG &&
    !I_CV_WDATA[1] |-> ##[1:4] !O_FAST_PWM)
    else $error("fast pwm kept with bit clear");
  a_serial_on: assert property (wtake && I_CV_NUM == CV_EXTENDED_CONFIG &&
    I_CV_WDATA[3] |-> ##[1:4] O_SERIAL_FN_EN)
    else $error("serial interface not enabled");
endmodule

// file: tb/dcb_station.sv
// Command station model issuing variable reads and writes
module dcb_station (
  // Clock and answer
  input  wire logic       i_clk,
  input  wire logic       i_ack,
  input  wire logic       i_err,
  input  wire logic [7:0] i_rdata,
  // Requests
  output logic            o_wr,
  output logic            o_rd,
  output logic            o_pml,
  output logic [8:0]      o_num,
  output logic [7:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_pml = 1'b0;
    o_num = 9'h000;
    o_wdata = 8'h00;
  end
  // One access, answer awaited under a bound
  task automatic access(input logic w, input logic [8:0] n, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
    q = 8'hxx;
    e = 1'bx;
    repeat (gap + 1) @(posedge i_clk);
    #1;
    o_wr = w;
    o_rd = ~w;
    o_num = n;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    repeat (6) begin
      @(posedge i_clk);
      if (i_ack === 1'b1) begin
        q = i_rdata;
        e = i_err;
        break;
      end
    end
    #1;
    o_num = ~o_num;
    o_wdata = ~o_wdata;
  endtask
endmodule

// file: tb/tb.sv
// Testbench for the configuration-variable bank
module tb;
  import dcb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk;
  logic                   rst_n;
  logic                   wr;
  logic                   rd;
  logic                   pml;
  logic [8:0]             num;
  logic [7:0]             wdata;
  logic [7:0]             rdata;
  logic                   ack;
  logic                   err;
  logic [7:0]             speed;
  logic                   fwd;
  logic [NUM_KEYS-1:0]    keys;
  logic                   pwm;
  logic                   comp;
  logic                   fast;
  logic                   ser;
  logic [NUM_OUTPUTS-1:0] fout;
  int                     num_errors = 0;
  int                     compares = 0;
  ////////////////////////////////////////////////////////////////////////////
  dcb_cv_bank u_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_CV_WR(wr), .I_CV_RD(rd),
    .I_MAIN_LINE_PROGRAMMING(pml), .I_CV_NUM(num), .I_CV_WDATA(wdata),
    .O_CV_RDATA(rdata), .O_CV_ACK(ack), .O_CV_ERR(err), .I_SPEED(speed),
    .I_CORRECTION(8'h20), .I_FORWARD(fwd), .I_KEYS(keys), .O_MOTOR_PWM(pwm),
    .O_COMP_ACTIVE(comp), .O_FAST_PWM(fast), .O_SERIAL_FN_EN(ser), .O_FUNC_OUT(fout));
  dcb_station u_st (.i_clk(clk), .i_ack(ack), .i_err(err), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd), .o_pml(pml), .o_num(num), .o_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wrv(input logic [8:0] n, input logic [7:0] d, input logic ee);
    logic [7:0] q;
    logic       e;
    u_st.access(1'b1, n, d, q, e);
    chk("wr err", 16'(e), 16'(ee));
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rdv(input logic [8:0] n, input logic [7:0] x, input logic ee);
    logic [7:0] q;
    logic       e;
    u_st.access(1'b0, n, 8'h00, q, e);
    chk("rd err", 16'(e), 16'(ee));
    chk("rd data", 16'(q), 16'(x));
  endtask
  task automatic period(input int x);
    int   e;
    int   p;
    logic pv;
    e = 0;
    p = 0;
    pv = pwm;
    repeat (4000) begin
      @(posedge clk);
      #1;
      if (e == 2) p++;
      if (pwm && !pv) e++;
      pv = pwm;
      if (e == 3) break;
    end
    chk("period", 16'(p), 16'(x));
  endtask
  task automatic setk(input logic [NUM_KEYS-1:0] k, input logic f, input logic [5:0] x);
    keys = k;
    fwd = f;
    repeat (2) @(posedge clk);
    #1;
    chk("outputs", 16'(fout), 16'(x));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_pwm;
    chk("serial", 16'(ser), 16'h0);
    rdv(CV_EXTENDED_CONFIG, 8'h14, 1'b0);
    rdv(CV_MOTOR_CONFIG, RST_MOTOR_CONFIG, 1'b0);
    chk("fast", 16'(fast), 16'h1);
    speed = 8'h40;
    period(PWM_FAST_CYCLES);
    wrv(CV_MOTOR_CONFIG, 8'h00, 1'b0);
    chk("fast", 16'(fast), 16'h0);
    period(PWM_SLOW_CYCLES);
    wrv(CV_MOTOR_CONFIG, 8'h02, 1'b0);
    wrv(CV_CONTROL_INFLUENCE, 8'h00, 1'b0);
    chk("comp", 16'(comp), 16'h0);
    wrv(CV_START_VOLTAGE, 8'h08, 1'b0);
    u_st.o_pml = 1'b1;
    wrv(CV_CONTROL_INFLUENCE, 8'h80, 1'b0);
    u_st.o_pml = 1'b0;
    chk("comp", 16'(comp), 16'h1);
    rdv(CV_START_VOLTAGE, 8'h08, 1'b0);
    speed = 8'h00;
    wrv(CV_EXTENDED_CONFIG, 8'h1c, 1'b0);
    chk("serial", 16'(ser), 16'h1);
  endtask
  task automatic t_window;
    wrv(CV_INDEX_PAGE_HIGH, 8'h10, 1'b0);
    wrv(CV_INDEX_PAGE_LOW, 8'h02, 1'b0);
    for (int r = 0; r < 16; r++) begin
      wrv(9'(257 + 16 * r), 8'h00, 1'b0);
      wrv(9'(266 + 16 * r), r < 4 ? 8'h20 : 8'h00, 1'b0);
    end
    wrv(9'h101, 8'h60, 1'b0);
    wrv(9'h141, 8'h22, 1'b0);
    wrv(9'h14a, 8'h03, 1'b0);
    setk(29'h1, 1'b1, 6'h20);
    setk(29'h5, 1'b1, 6'h23);
    setk(29'h5, 1'b0, 6'h20);
    setk(29'h0, 1'b1, 6'h00);
    wrv(9'h14a, 8'h3f, 1'b0);
    setk(29'h4, 1'b1, 6'h3f);
    wrv(CV_INDEX_PAGE_LOW, 8'h03, 1'b0);
    wrv(9'h10a, 8'h55, 1'b0);
    rdv(9'h10a, 8'h55, 1'b0);
    wrv(CV_INDEX_PAGE_LOW, 8'h05, 1'b0);
    wrv(9'h10a, 8'h11, 1'b1);
    rdv(9'h10a, 8'h00, 1'b1);
    wrv(CV_INDEX_PAGE_LOW, 8'h02, 1'b0);
    wrv(CV_INDEX_PAGE_HIGH, 8'h0f, 1'b0);
    rdv(9'h10a, 8'h00, 1'b1);
    wrv(CV_INDEX_PAGE_HIGH, 8'h10, 1'b0);
    rdv(9'h10a, 8'h20, 1'b0);
  endtask
  task automatic results;
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    speed = 8'h00;
    fwd = 1'b1;
    keys = '0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_pwm();
    t_window();
    results();
  end
  initial begin
    #2000000;
    num_errors++;
    results();
  end
endmodule
bind dcb_cv_bank dcb_chk u_chk (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CV_WR(I_CV_WR),
  .I_CV_RD(I_CV_RD), .I_CV_NUM(I_CV_NUM), .I_CV_WDATA(I_CV_WDATA), .O_CV_ACK(O_CV_ACK),
  .O_CV_ERR(O_CV_ERR), .O_COMP_ACTIVE(O_COMP_ACTIVE), .O_FAST_PWM(O_FAST_PWM),
  .O_SERIAL_FN_EN(O_SERIAL_FN_EN));
